// >>> inc/startup_timeout_map.vh
`ifndef STARTUP_TIMEOUT_MAP_VH
`define STARTUP_TIMEOUT_MAP_VH
// ----------------------------------------
// command codes
// ----------------------------------------
`define CMD_STARTUP_TIMEOUT_LIMIT 8'h62
`define CMD_STARTUP_TIMEOUT_RESPONSE 8'h63
// ----------------------------------------
// response byte fields
// ----------------------------------------
`define RESP_ACTION_HI 7
`define RESP_ACTION_LO 6
`define RESP_RETRY_HI 5
`define RESP_RETRY_LO 3
`define RESP_DELAY_HI 2
`define RESP_DELAY_LO 0
`define ACT_IGNORE 2'b00
`define ACT_RUN_DELAY 2'b01
`define ACT_DISABLE_RETRY 2'b10
`define ACT_LATCH_OFF 2'b11
`define RETRY_NONE 3'b000
`define RETRY_FOREVER 3'b111
// ----------------------------------------
// reset values
// ----------------------------------------
`define LIMIT_RESET 16'h0000
`define RESPONSE_RESET 8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define MS_TIME_NS 1000000
`define CLK_PERIOD_NS 10
`define MS_CYCLES (`MS_TIME_NS / `CLK_PERIOD_NS)
`endif

// >>> hdl/startup_timeout_fault_handler.v
`timescale 1ns/1ps
`default_nettype none
`include "startup_timeout_map.vh"

// Behaviour
// [RULE_01] A 16-bit startup limit in milliseconds is written and read back by the host.
// [RULE_02] Output not above the undervoltage limit within the limit raises a timeout fault.
// [RULE_03] A limit of zero disables the timeout and the fault is never raised.
// [RULE_04] The response byte holds the action in bits 7:6, and code 00 ignores the fault.
// [RULE_05] Code 01 keeps running for the delay, then follows the retry field if still faulty.
// [RULE_06] Code 10 disables the output at once and then follows the retry field.
// [RULE_07] Code 11 latches the output off until a clear, reset, off-on cycle or bias loss.
// [RULE_08] Retry field 000 keeps the output off until the fault is cleared.
// [RULE_09] Retry codes 001 to 101 try one to five restarts, then stay off until cleared.
// [RULE_10] Restart attempts start a delay field count of time units apart.
// [RULE_11] Retry 110 tries six times and 111 retries until commanded off.
// [RULE_12] The delay field selects two to the power of its value time units, 1 to 128.
// [RULE_13] The time unit is the one configured for output voltage faults.
// [RULE_14] The attempt counter clears after a good startup or a fault clear; the code clears it on a clear request only in S_OFF.
module startup_timeout_fault_handler #(
  parameter MS_CYCLES = `MS_CYCLES,
  parameter UNIT_W = 24
) (
  input wire clk,
  input wire rst_n,
  input wire [7:0] cmd_code,
  input wire [15:0] wr_data,
  input wire wr_en,
  output reg [15:0] rd_data,
  input wire [UNIT_W-1:0] vout_fault_unit_ms,
  input wire enable_cmd,
  input wire uv_ok_raw,
  input wire clear_faults,
  output reg output_enable_ff,
  output reg timeout_fault_ff,
  output reg latched_off_ff
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [15:0] limit_ff;
  reg [7:0] response_ff;
  wire [1:0] action = response_ff[`RESP_ACTION_HI:`RESP_ACTION_LO];
  wire [2:0] retry_set = response_ff[`RESP_RETRY_HI:`RESP_RETRY_LO];
  wire [2:0] delay_sel = response_ff[`RESP_DELAY_HI:`RESP_DELAY_LO];

  // host writes; the limit is word wide, the response a byte
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      limit_ff <= `LIMIT_RESET;
      response_ff <= `RESPONSE_RESET;
    end else if (wr_en) begin
      if (cmd_code == `CMD_STARTUP_TIMEOUT_LIMIT) begin
        limit_ff <= wr_data; // RULE_01
      end else if (cmd_code == `CMD_STARTUP_TIMEOUT_RESPONSE) begin
        response_ff <= wr_data[7:0]; // RULE_04
      end
    end
  end

  // read back, unknown codes give zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
    end else begin
      case (cmd_code)
        `CMD_STARTUP_TIMEOUT_LIMIT: rd_data <= limit_ff; // RULE_01
        `CMD_STARTUP_TIMEOUT_RESPONSE: rd_data <= {8'h00, response_ff};
        default: rd_data <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [2:0] sync1_ff;
  reg [2:0] sync2_ff;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 3'b000;
      sync2_ff <= 3'b000;
    end else begin
      sync1_ff <= {clear_faults, uv_ok_raw, enable_cmd};
      sync2_ff <= sync1_ff;
    end
  end
  wire en_s = sync2_ff[0];
  wire uv_ok = sync2_ff[1];
  wire clr_s = sync2_ff[2];
  reg en_d_ff;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_d_ff <= 1'b0;
    end else begin
      en_d_ff <= en_s;
    end
  end
  // an off-then-on cycle counts as a clear
  wire fault_clear = clr_s | (en_s & ~en_d_ff); // RULE_07

  // ----------------------------------------
  // millisecond tick
  // ----------------------------------------
  reg [31:0] pre_ff;
  wire ms_tick = (pre_ff == MS_CYCLES - 1);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 32'h0000_0000;
    end else begin
      pre_ff <= ms_tick ? 32'h0000_0000 : pre_ff + 32'h0000_0001;
    end
  end

  // delay length in ms: 2^sel units of the vout fault unit
  function [UNIT_W+7:0] delay_ms;
    input [2:0] sel;
    input [UNIT_W-1:0] unit;
    begin
      delay_ms = {8'h00, unit} << sel; // RULE_12 RULE_13
    end
  endfunction

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  localparam S_IDLE = 3'd0;
  localparam S_RAMP = 3'd1;
  localparam S_RUN = 3'd2;
  localparam S_GRACE = 3'd3;
  localparam S_WAIT = 3'd4;
  localparam S_OFF = 3'd5;
  // counter increment sized to the counter, so a wider unit never truncates silently
  localparam [UNIT_W+7:0] CNT_ONE = {{(UNIT_W+7){1'b0}}, 1'b1};

  reg [2:0] state_ff;
  reg [UNIT_W+7:0] cnt_ff;
  reg [2:0] tries_ff;
  wire limit_hit = (limit_ff != 16'h0000) && ms_tick &&
                   (cnt_ff + CNT_ONE >= {{(UNIT_W-8){1'b0}}, limit_ff});
  wire delay_done = ms_tick && (cnt_ff + CNT_ONE >= delay_ms(delay_sel, vout_fault_unit_ms));
  wire retry_left = (retry_set == `RETRY_FOREVER) || (tries_ff < retry_set); // RULE_09 RULE_11

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      cnt_ff <= {(UNIT_W+8){1'b0}};
      tries_ff <= 3'b000;
      output_enable_ff <= 1'b0;
      timeout_fault_ff <= 1'b0;
      latched_off_ff <= 1'b0;
    end else if (!en_s) begin
      // commanded off ends every attempt, latch-off and endless retry; the fault flag keeps its value
      state_ff <= S_IDLE;
      output_enable_ff <= 1'b0;
      tries_ff <= 3'b000;
      latched_off_ff <= 1'b0;
      // a clear request is honoured while off too, nothing can set the flag here
      if (clr_s) begin
        timeout_fault_ff <= 1'b0; // RULE_07
      end
    end else begin
      if (ms_tick) begin
        cnt_ff <= cnt_ff + CNT_ONE;
      end
      case (state_ff)
        S_IDLE: begin
          state_ff <= S_RAMP;
          cnt_ff <= {(UNIT_W+8){1'b0}};
          output_enable_ff <= 1'b1;
        end
        S_RAMP: begin
          if (uv_ok) begin
            state_ff <= S_RUN;
            tries_ff <= 3'b000; // RULE_14
          end else if (limit_hit) begin // RULE_02 RULE_03
            timeout_fault_ff <= 1'b1;
            cnt_ff <= {(UNIT_W+8){1'b0}};
            case (action)
              `ACT_IGNORE: state_ff <= S_RUN; // RULE_04
              `ACT_RUN_DELAY: state_ff <= S_GRACE; // RULE_05
              `ACT_DISABLE_RETRY: begin // RULE_06
                output_enable_ff <= 1'b0;
                state_ff <= retry_left ? S_WAIT : S_OFF; // RULE_08
                latched_off_ff <= ~retry_left;
              end
              default: begin // RULE_07
                output_enable_ff <= 1'b0;
                latched_off_ff <= 1'b1;
                state_ff <= S_OFF;
              end
            endcase
          end
        end
        S_GRACE: begin
          if (uv_ok) begin
            state_ff <= S_RUN;
            tries_ff <= 3'b000;
          end else if (delay_done) begin // RULE_05
            output_enable_ff <= 1'b0;
            cnt_ff <= {(UNIT_W+8){1'b0}};
            state_ff <= retry_left ? S_WAIT : S_OFF;
            latched_off_ff <= ~retry_left;
          end
        end
        S_WAIT: begin
          if (delay_done) begin // RULE_10
            tries_ff <= tries_ff + 3'b001;
            state_ff <= S_IDLE;
          end
        end
        S_OFF: begin
          if (fault_clear) begin // RULE_07 RULE_14
            latched_off_ff <= 1'b0;
            tries_ff <= 3'b000;
            state_ff <= S_IDLE;
          end
        end
        S_RUN: begin
          output_enable_ff <= 1'b1;
        end
        default: state_ff <= S_IDLE;
      endcase
      // clear loses only to a fault set in the same cycle
      if (fault_clear && !(state_ff == S_RAMP && limit_hit && !uv_ok)) begin
        timeout_fault_ff <= 1'b0;
      end
    end
  end

endmodule // startup_timeout_fault_handler
`default_nettype wire

// >>> bench/power_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// power stage seen from the sequencer
// ----------------------------------------
module power_stage_model (
  input wire logic clk,
  input wire logic en,
  input wire logic [15:0] rise,
  output logic uv_ok = 1'b0
);
  logic [15:0] cnt_ff = 16'h0000;
  // output climbs while enabled and collapses at once when disabled;
  // rise of ffff models a rail that never comes up
  always @(posedge clk) begin
    cnt_ff <= en ? cnt_ff + {15'h0000, cnt_ff != 16'hffff} : 16'h0000;
    uv_ok <= en && rise != 16'hffff && cnt_ff >= rise;
  end
endmodule // power_stage_model
`default_nettype wire

// >>> bench/startup_timeout_checker.sv
`timescale 1ns/1ps
`default_nettype none
module startup_timeout_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic [15:0] rd_data,
  input wire logic uv_ok_raw,
  input wire logic output_enable_ff,
  input wire logic timeout_fault_ff,
  input wire logic latched_off_ff
);
  logic [15:0] lim_ff;
  logic [1:0] act_ff;
  // shadow registers, so fault reactions can be judged by setting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lim_ff <= 16'h0000;
      act_ff <= 2'b00;
    end else if (wr_en && cmd_code == 8'h62) begin
      lim_ff <= wr_data;
    end else if (wr_en && cmd_code == 8'h63) begin
      act_ff <= wr_data[7:6];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_limit_readback: assert property (
    (wr_en && cmd_code == 8'h62) ##1 (!wr_en && cmd_code == 8'h62) |=>
    rd_data == $past(wr_data, 2)) else $error("limit read back wrong");
  a_other_reads_zero: assert property (
    !(cmd_code inside {8'h62, 8'h63}) |=> rd_data == 16'h0000) else $error("unmapped read");
  a_resp_one_byte: assert property (
    cmd_code == 8'h63 |=> rd_data[15:8] == 8'h00) else $error("response upper byte set");
  a_zero_no_fault: assert property (
    $rose(timeout_fault_ff) |-> $past(lim_ff) != 16'h0000) else $error("fault with zero limit");
  a_good_no_fault: assert property (
    uv_ok_raw [*8] |-> !$rose(timeout_fault_ff)) else $error("fault while rail is up");
  a_ignore_keeps_on: assert property (
    $rose(timeout_fault_ff) && act_ff == 2'b00 |-> output_enable_ff) else $error("ignore shut");
  a_run_keeps_on: assert property (
    $rose(timeout_fault_ff) && act_ff == 2'b01 |-> output_enable_ff [*2]) else $error("early off");
  a_disable_now: assert property (
    $rose(timeout_fault_ff) && act_ff == 2'b10 |-> ##[0:1] !output_enable_ff) else $error("late off");
  a_latch_now: assert property (
    $rose(timeout_fault_ff) && act_ff == 2'b11 |-> ##[0:1] latched_off_ff) else $error("no latch");
  a_latch_holds_off: assert property (
    latched_off_ff |-> !output_enable_ff) else $error("on while latched off");
  c_fault: cover property ($rose(timeout_fault_ff));
  c_latched: cover property ($rose(latched_off_ff));
  c_restart: cover property ($fell(output_enable_ff) ##[1:300] $rose(output_enable_ff));
endmodule // startup_timeout_checker
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [15:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic [23:0] vout_fault_unit_ms = 24'h00_0001;
  logic enable_cmd = 1'b0;
  logic clear_faults = 1'b0;
  logic [15:0] rise = 16'hffff;
  logic [15:0] v;
  logic oe_q = 1'b0;
  logic [2:0] rtab [4] = '{3'd0, 3'd1, 3'd2, 3'd7};
  wire uv_ok_raw;
  wire [15:0] rd_data;
  wire output_enable_ff, timeout_fault_ff, latched_off_ff;
  int err_count = 0;
  int total_checks = 0;
  int rises = 0;
  int gap = 0;
  int low_run = 0;
  localparam int MSC = 10;
  startup_timeout_fault_handler #(.MS_CYCLES(MSC)) uut (
    .clk(clk),
    .rst_n(rst_n),
    .cmd_code(cmd_code),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_data(rd_data),
    .vout_fault_unit_ms(vout_fault_unit_ms),
    .enable_cmd(enable_cmd),
    .uv_ok_raw(uv_ok_raw),
    .clear_faults(clear_faults),
    .output_enable_ff(output_enable_ff),
    .timeout_fault_ff(timeout_fault_ff),
    .latched_off_ff(latched_off_ff)
  );
  power_stage_model ps (.clk(clk), .en(output_enable_ff), .rise(rise), .uv_ok(uv_ok_raw));
  always #5 clk = ~clk;
  // every rising output enable is one start attempt; gap is the off time just before it
  always @(posedge clk) begin
    oe_q <= output_enable_ff;
    if (output_enable_ff && !oe_q) begin
      rises++;
      gap = low_run;
    end
    low_run = output_enable_ff ? 0 : low_run + 1;
  end
  task check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk);
    cmd_code = c;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  task rd(input logic [7:0] c, input logic [15:0] e);
    @(negedge clk);
    cmd_code = c;
    repeat (2) @(negedge clk);
    check(rd_data, e);
  endtask
  // set up, power on, wait for the fault for at most n cycles
  task go(input logic [15:0] l, input logic [7:0] r, input logic [15:0] z, input int n);
    wr(8'h62, l);
    wr(8'h63, {8'h00, r});
    rise = z;
    rises = 0;
    enable_cmd = 1'b1;
    for (int i = 0; i < n && timeout_fault_ff !== 1'b1; i++) @(negedge clk);
  endtask
  // off command plus clear request; pins are synchronised, so hold both a while
  task stop();
    enable_cmd = 1'b0;
    clear_faults = 1'b1;
    repeat (8) @(negedge clk);
    clear_faults = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  function automatic logic [15:0] exp_rises(input logic [2:0] r);
    return {13'h0000, r} + 16'h0001;
  endfunction
  // off time between shutdown and restart: 2^sel units of unit ms, plus the idle cycle
  function automatic logic [15:0] exp_gap(input int unit, input int sel);
    return 16'(MSC * (unit << sel) + 1);
  endfunction
  task print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #500000;
    err_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(42925));
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    rd(8'h62, 16'h0000);
    rd(8'h63, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      v = 16'($urandom);
      wr(8'h62, v);
      rd(8'h62, v);
      wr(8'h63, v);
      rd(8'h63, {8'h00, v[7:0]});
      rd({4'h5, v[11:8]}, 16'h0000);
    end
    // each response code, no retry, delay of two units
    for (int a = 0; a < 4; a++) begin
      go(16'h0002, {a[1:0], 6'h01}, 16'hffff, 200);
      check(timeout_fault_ff, 1'b1);
      repeat (3) @(negedge clk);
      check(output_enable_ff, a < 2);
      repeat (40) @(negedge clk);
      check(output_enable_ff, a == 0);
      check(latched_off_ff, a != 0);
      stop();
    end
    go(16'h0000, 8'h80, 16'hffff, 300);
    check(timeout_fault_ff, 1'b0);
    stop();
    go(16'h0003, 8'h80, 16'h0005, 100);
    check(output_enable_ff, 1'b1);
    check(timeout_fault_ff, 1'b0);
    stop();
    // disable and retry, counts 0, 1, 2 and endless, random delay field, unit 1 to 4 ms
    for (int j = 0; j < 4; j++) begin
      v = 16'($urandom);
      vout_fault_unit_ms = 24'(j + 1);
      go(16'h0001, {2'b10, rtab[j], 1'b0, v[1:0]}, 16'hffff, 200);
      repeat (900) @(negedge clk);
      if (rtab[j] != 3'd7) check(rises, exp_rises(rtab[j]));
      else check(rises >= 3, 1'b1);
      if (rtab[j] != 3'd0) check(16'(gap), exp_gap(j + 1, v[1:0]));
      check(latched_off_ff, rtab[j] != 3'd7);
      stop();
    end
    print_verdict();
  end
endmodule // testbench
bind startup_timeout_fault_handler startup_timeout_checker chk (
  .clk(clk),
  .rst_n(rst_n),
  .cmd_code(cmd_code),
  .wr_data(wr_data),
  .wr_en(wr_en),
  .rd_data(rd_data),
  .uv_ok_raw(uv_ok_raw),
  .output_enable_ff(output_enable_ff),
  .timeout_fault_ff(timeout_fault_ff),
  .latched_off_ff(latched_off_ff)
);
`default_nettype wire
